// ### eac_dev_end.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - data read: byte in low data next cycle
// - low data holds until read or write
// - write needs 55h, AAh, then trigger
// - trigger refused while write allow clear
// - clearing write allow keeps running write
// - write allow cleared by hardware only on reset or reset request
// - write end clears trigger, sets complete flag
// - only software or reset clears complete flag
// - triggers set-only, hardware clears on completion
// - abort flag set when reset cuts write
// - space select picks program or data memory
// - program read uses second cycle after trigger
// - program word: six high, eight low bits
// - high address supplies four upper bits
// - low address gives byte or low address
// - write trigger in program space does nothing
// - write allow cleared on power-up
// - writes blocked during power-up timer
// - unimplemented bits read as zero
// - two no-ops follow a program read trigger; only the access in the second cycle is dropped
// - interrupts off around unlock sequence; block has no interrupt input, any other access breaks the sequence
// - unlock port reads all zeros
// - byte write erases then programs
module eac_dev_end
   import eac_pkg::*;
#(
   parameter int DEPTH        = 256,              // data eeprom bytes
   parameter int PWRT_CYCLES  = EAC_PWRT_CYCLES,  // power-up timer length
   parameter int WRITE_CYCLES = EAC_WRITE_CYCLES  // erase plus program
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // master clear, watchdog or brownout reset request
   input  wire logic        abort_req,
   // program flash read port
   output logic      [11:0] pm_addr,
   input  wire logic [13:0] pm_rdata,
   // status
   output logic             write_complete,
   output logic             write_busy,
   // sfr port
   eac_sfr_if.dev           sfr
);
   localparam int PW = $clog2(PWRT_CYCLES + 1);
   localparam int WW = $clog2(WRITE_CYCLES + 1);
   localparam logic [PW-1:0] PWRT_END = PW'(PWRT_CYCLES);
   localparam logic [WW-1:0] WR_END   = WW'(WRITE_CYCLES);
   localparam logic [WW-1:0] WR_HALF  = WW'(WRITE_CYCLES / 2);

   logic [7:0]    mem [DEPTH];      // data eeprom array
   logic [7:0]    dat_lo_r;         // ee_data_low_byte
   logic [5:0]    dat_hi_r;         // ee_data_high_byte bits 5-0
   logic [7:0]    adr_lo_r;         // ee_address_low_byte
   logic [3:0]    adr_hi_r;         // ee_address_high_byte bits 3-0
   logic          pgd_r;            // space_select
   logic          wabort_r;         // write_abort_flag
   logic          wallow_r;         // write_allow
   logic          wr_r;             // write trigger / busy
   logic          rd_r;             // read trigger
   logic          wcf_r;            // write_complete_flag
   logic [7:0]    rdata_r;          // registered read data
   logic [1:0]    fcnt_r;           // cycles since program read trigger
   logic          slot_r;           // fetch slot marker
   logic [PW-1:0] pwrt_r;           // power-up timer
   logic          pwrt_done_r;      // timer expired
   logic [WW-1:0] wcnt_r;           // write cycle counter
   logic [7:0]    wbyte_r;          // byte latched at write start
   logic [7:0]    waddr_r;          // address latched at write start
   eac_unlock_t   ul_r;             // unlock detector state

   logic ctrl_wr;    // write to control register
   logic rd_go;      // read trigger accepted
   logic wr_go;      // write trigger accepted
   logic wr_done;    // last write cycle
   logic any_acc;    // any register access

   assign ctrl_wr = sfr.wr && sfr.addr == EAC_CTRL;
   assign any_acc = sfr.wr | sfr.rd;
   // read trigger only sets; busy read ignores a second one
   assign rd_go   = ctrl_wr && sfr.wdata[EAC_B_RD] && !rd_r;
   // write trigger needs unlock, write allow, data space, timer
   assign wr_go   = ctrl_wr && sfr.wdata[EAC_B_WR] && !wr_r
                    && ul_r == EAC_UL_KEY2
                    && wallow_r
                    && !sfr.wdata[EAC_B_PGD] && !pgd_r
                    && pwrt_done_r;
   assign wr_done = wr_r && wcnt_r == WR_END;

   // power-up timer runs once after power-on reset only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwrt_r      <= '0;
         pwrt_done_r <= 1'b0;
      end else if (!pwrt_done_r) begin
         pwrt_r      <= pwrt_r + PW'(1);
         pwrt_done_r <= pwrt_r == PWRT_END - PW'(1);
      end
   end

   // unlock detector; any other access breaks the sequence
   always_ff @(posedge clk) begin
      if (!rst_n || abort_req) begin
         ul_r <= EAC_UL_IDLE;
      end else if (sfr.wr && sfr.addr == EAC_UNLK) begin
         if (sfr.wdata == EAC_KEY1) begin
            ul_r <= EAC_UL_KEY1;
         end else if (sfr.wdata == EAC_KEY2 && ul_r == EAC_UL_KEY1) begin
            ul_r <= EAC_UL_KEY2;
         end else begin
            ul_r <= EAC_UL_IDLE;
         end
      end else if (any_acc) begin
         ul_r <= EAC_UL_IDLE;
      end
   end

   // address registers
   always_ff @(posedge clk) begin
      if (!rst_n || abort_req) begin
         adr_lo_r <= EAC_RST_BYTE;
         adr_hi_r <= EAC_RST_BYTE[3:0];
      end else if (sfr.wr) begin
         if (sfr.addr == EAC_ADRL) adr_lo_r <= sfr.wdata;
         if (sfr.addr == EAC_ADRH) adr_hi_r <= sfr.wdata[3:0];
      end
   end
   assign pm_addr = {adr_hi_r, adr_lo_r};

   // data registers: loaded by reads or software writes only
   always_ff @(posedge clk) begin
      if (!rst_n || abort_req) begin
         dat_lo_r <= EAC_RST_BYTE;
         dat_hi_r <= EAC_RST_BYTE[5:0];
      end else if (rd_go && !sfr.wdata[EAC_B_PGD]) begin
         dat_lo_r <= mem[adr_lo_r];
      end else if (slot_r) begin
         dat_lo_r <= pm_rdata[7:0];
         dat_hi_r <= pm_rdata[13:8];
      end else if (sfr.wr) begin
         if (sfr.addr == EAC_DATL) dat_lo_r <= sfr.wdata;
         if (sfr.addr == EAC_DATH) dat_hi_r <= sfr.wdata[5:0];
      end
   end

   // read engine; data space done at once, program space waits a slot
   always_ff @(posedge clk) begin
      if (!rst_n || abort_req) begin
         rd_r   <= 1'b0;
         fcnt_r <= 2'h0;
         slot_r <= 1'b0;
      end else if (rd_go) begin
         rd_r   <= sfr.wdata[EAC_B_PGD];
         fcnt_r <= 2'h1;
         slot_r <= 1'b0;
      end else if (rd_r) begin
         fcnt_r <= fcnt_r + 2'h1;
         slot_r <= fcnt_r == 2'(EAC_FETCH_DELAY - 1);
         if (slot_r) begin
            rd_r <= 1'b0;
         end
      end else begin
         slot_r <= 1'b0;
      end
   end
   assign sfr.fetch_slot = slot_r;

   // control bits written by software
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pgd_r    <= 1'b0;
         wallow_r <= 1'b0;
      end else if (abort_req) begin
         pgd_r    <= 1'b0;
         wallow_r <= 1'b0;
      end else if (ctrl_wr) begin
         pgd_r    <= sfr.wdata[EAC_B_PGD];
         wallow_r <= sfr.wdata[EAC_B_WALLOW];
      end
   end

   // write engine: erase first half, program second half
   always_ff @(posedge clk) begin
      if (!rst_n || abort_req) begin
         wr_r   <= 1'b0;
         wcnt_r <= '0;
      end else if (wr_go) begin
         wr_r    <= 1'b1;
         wcnt_r  <= '0;
         wbyte_r <= dat_lo_r;
         waddr_r <= adr_lo_r;
      end else if (wr_r) begin
         wcnt_r <= wcnt_r + WW'(1);
         if (wcnt_r == '0) begin
            mem[waddr_r] <= EAC_ERASED;
         end
         if (wcnt_r == WR_HALF) begin
            mem[waddr_r] <= wbyte_r;
         end
         if (wr_done) begin
            wr_r <= 1'b0;
         end
      end
   end

   // abort flag; a cut write sets it, a finished one clears it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wabort_r <= 1'b0;
      end else if (abort_req) begin
         wabort_r <= wabort_r | wr_r;
      end else if (wr_done) begin
         wabort_r <= 1'b0;
      end else if (ctrl_wr) begin
         wabort_r <= sfr.wdata[EAC_B_WABORT];
      end
   end

   // complete flag; set wins over a software clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wcf_r <= 1'b0;
      end else if (wr_done) begin
         wcf_r <= 1'b1;
      end else if (sfr.wr && sfr.addr == EAC_FLAG) begin
         wcf_r <= sfr.wdata[EAC_B_WCF];
      end
   end

   // registered read mux, unused bits zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= EAC_RST_BYTE;
      end else if (sfr.rd) begin
         unique case (sfr.addr)
            EAC_DATL: rdata_r <= dat_lo_r;
            EAC_ADRL: rdata_r <= adr_lo_r;
            EAC_DATH: rdata_r <= {2'h0, dat_hi_r};
            EAC_ADRH: rdata_r <= {4'h0, adr_hi_r};
            EAC_CTRL: rdata_r <= {pgd_r, 3'h0, wabort_r, wallow_r,
                                  wr_r, rd_r};
            EAC_FLAG: rdata_r <= {7'h00, wcf_r};
            default:  rdata_r <= EAC_RST_BYTE;
         endcase
      end
   end
   assign sfr.rdata      = rdata_r;
   assign write_complete = wcf_r;
   assign write_busy     = wr_r;
endmodule : eac_dev_end
`default_nettype wire

// ### eac_pkg.sv
package eac_pkg;
   // register index on the sfr port
   localparam logic [2:0] EAC_DATL = 3'h0;  // ee_data_low_byte
   localparam logic [2:0] EAC_ADRL = 3'h1;  // ee_address_low_byte
   localparam logic [2:0] EAC_DATH = 3'h2;  // ee_data_high_byte
   localparam logic [2:0] EAC_ADRH = 3'h3;  // ee_address_high_byte
   localparam logic [2:0] EAC_CTRL = 3'h4;  // ee_access_control
   localparam logic [2:0] EAC_UNLK = 3'h5;  // write_unlock_port
   localparam logic [2:0] EAC_FLAG = 3'h6;  // write_complete_flag holder
   // control register bit positions
   localparam int EAC_B_RD    = 0;
   localparam int EAC_B_WR    = 1;
   localparam int EAC_B_WALLOW = 2;         // write_allow
   localparam int EAC_B_WABORT = 3;         // write_abort_flag
   localparam int EAC_B_PGD   = 7;
   localparam int EAC_B_WCF   = 0;          // bit in flag register
   // unlock key bytes
   localparam logic [7:0] EAC_KEY1 = 8'h55;
   localparam logic [7:0] EAC_KEY2 = 8'hAA;
   // reset values
   localparam logic [7:0] EAC_RST_BYTE = 8'h00;
   localparam logic [7:0] EAC_ERASED   = 8'hFF;
   // timing
   localparam int EAC_CLK_PERIOD_NS = 10;
   localparam int EAC_PWRT_TIME_MS  = 64;
   localparam int EAC_PWRT_CYCLES   =
      EAC_PWRT_TIME_MS * 1_000_000 / EAC_CLK_PERIOD_NS;
   localparam int EAC_WRITE_CYCLES  = 16;  // erase half then program half
   localparam int EAC_FETCH_DELAY   = 2;   // slot is 2nd cycle after trigger
   // unlock detector states
   typedef enum logic [1:0] {EAC_UL_IDLE, EAC_UL_KEY1, EAC_UL_KEY2}
      eac_unlock_t;
endpackage : eac_pkg

// ### eac_sfr_if.sv
`timescale 1ns/100ps
`default_nettype none
// sfr port between the cpu core and the access controller
interface eac_sfr_if;
   logic [2:0] addr;        // register index
   logic [7:0] wdata;       // write data
   logic       wr;          // write strobe
   logic       rd;          // read strobe
   logic [7:0] rdata;       // read data, cycle after rd
   logic       fetch_slot;  // program read steals this cycle
   modport dev (input addr, wdata, wr, rd, output rdata, fetch_slot);
   modport cpu (output addr, wdata, wr, rd, input rdata, fetch_slot);
endinterface : eac_sfr_if
`default_nettype wire

// ### eac_cpu_end.sv
`timescale 1ns/100ps
`default_nettype none
// cpu side: forwards register accesses, drops the one in the fetch slot
module eac_cpu_end
   import eac_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // user command port
   input  wire logic [2:0] u_addr,
   input  wire logic [7:0] u_wdata,
   input  wire logic       u_wr,
   input  wire logic       u_rd,
   output logic      [7:0] u_rdata,
   output logic            u_discard,
   // sfr port
   eac_sfr_if.cpu          sfr
);
   logic slot;   // instruction in this cycle is swallowed
   assign slot = sfr.fetch_slot;

   // forward strobes unless the flash fetch owns the cycle
   assign sfr.addr  = u_addr;
   assign sfr.wdata = u_wdata;
   assign sfr.wr    = u_wr & ~slot;
   assign sfr.rd    = u_rd & ~slot;
   // read data already comes from a device flop
   assign u_rdata   = sfr.rdata;

   // report a dropped access one cycle later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         u_discard <= 1'b0;
      end else begin
         u_discard <= slot & (u_wr | u_rd);
      end
   end
endmodule : eac_cpu_end
`default_nettype wire

// ### eac_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
// watches the sfr port between the cpu end and the device end
module eac_chk_sva
   import eac_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // sfr port
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       fetch_slot
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // accesses in the stolen slot are dropped, so they are left out
   sequence rd_at(logic [2:0] a);
      rd && !fetch_slot && addr == a;
   endsequence
   sequence dm_trig;
      wr && !fetch_slot && addr == EAC_CTRL && wdata == 8'h01;
   endsequence
   unlk_zero_a: assert property (rd_at(EAC_UNLK) |=> rdata == 8'h00)
      else $error("unlock port read not zero");
   unmapped_zero_a: assert property (rd_at(3'h7) |=> rdata == 8'h00)
      else $error("unmapped index read not zero");
   adrh_top_a: assert property (rd_at(EAC_ADRH) |=> rdata[7:4] == 4'h0)
      else $error("high address top bits not zero");
   dath_top_a: assert property (rd_at(EAC_DATH) |=> rdata[7:6] == 2'b00)
      else $error("high data top bits not zero");
   ctrl_gap_a: assert property (rd_at(EAC_CTRL) |=> rdata[6:4] == 3'h0)
      else $error("control unused bits not zero");
   slot_pulse_a: assert property (fetch_slot |=> !fetch_slot)
      else $error("fetch slot longer than one cycle");
   slot_cause_a: assert property (fetch_slot |->
      $past(wr && addr == EAC_CTRL && wdata[EAC_B_PGD] && wdata[EAC_B_RD], 2))
      else $error("fetch slot without program read trigger");
   rd_clear_a: assert property (dm_trig ##1 rd_at(EAC_CTRL)
      |=> !rdata[EAC_B_RD])
      else $error("read trigger seen set");
   datl_hold_a: assert property (rd_at(EAC_DATL) ##1 rd_at(EAC_DATL)
      |=> $stable(rdata))
      else $error("low data changed between reads");
endmodule : eac_chk_sva
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
   import eac_pkg::*;
;
   localparam int PWRT = 20;      // short power-up timer for simulation
   logic        clk, rst_n, abort_req, u_wr, u_rd, u_discard, wc, wb;
   logic [2:0]  u_addr;
   logic [7:0]  u_wdata, u_rdata, a, d, ah;
   logic [11:0] pm_addr;
   logic [13:0] pm_rdata;
   logic [13:0] fl_m [4096];      // flash model, random content
   int          ee_m [256];       // eeprom model
   int          aq [$];           // addresses written
   int          err_total = 0, check_count = 0, cyc = 0, seed, i, k;
   assign pm_rdata = fl_m[pm_addr];
   eac_sfr_if sfr ();
   eac_cpu_end i_eac_cpu_end (.clk(clk), .rst_n(rst_n), .u_addr(u_addr),
      .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_rdata(u_rdata),
      .u_discard(u_discard), .sfr(sfr));
   eac_dev_end #(.PWRT_CYCLES(PWRT)) i_eac_dev_end (.clk(clk), .rst_n(rst_n),
      .abort_req(abort_req), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .write_complete(wc), .write_busy(wb), .sfr(sfr));
   eac_chk_sva i_eac_chk_sva (.clk(clk), .rst_n(rst_n), .addr(sfr.addr),
      .wdata(sfr.wdata), .wr(sfr.wr), .rd(sfr.rd), .rdata(sfr.rdata),
      .fetch_slot(sfr.fetch_slot));
   task automatic chk(input string n, input logic [7:0] s, e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // one write strobe, held until the edge that takes it
   task automatic wr_t(input logic [2:0] ad, input logic [7:0] dt);
      u_addr  <= ad;
      u_wdata <= dt;
      u_wr    <= 1'b1;
      u_rd    <= 1'b0;
      @(posedge clk);
   endtask : wr_t
   task automatic idle();
      u_wr <= 1'b0;
      u_rd <= 1'b0;
      @(posedge clk);
   endtask : idle
   // read strobe, data looked at in the following cycle only
   task automatic rdc(input logic [2:0] ad, input logic [7:0] e,
                      input string n);
      u_addr <= ad;
      u_rd   <= 1'b1;
      u_wr   <= 1'b0;
      @(posedge clk);
      u_rd <= 1'b0;
      #1;
      chk(n, u_rdata, e);
   endtask : rdc
   // key bytes must be the last two accesses before the trigger
   task automatic unl(input logic [7:0] c);
      wr_t(EAC_UNLK, EAC_KEY1);
      wr_t(EAC_UNLK, EAC_KEY2);
      wr_t(EAC_CTRL, c);
   endtask : unl
   task automatic ew(input logic [7:0] ad, dt);
      wr_t(EAC_ADRL, ad);
      wr_t(EAC_DATL, dt);
      wr_t(EAC_CTRL, 8'h04);
      unl(8'h06);
   endtask : ew
   // bounded wait for the write to end
   task automatic wt();
      #1;
      for (k = 0; k < 100 && wb !== 1'b0; k++) begin
         idle();
         #1;
      end
      chk("busy", {7'h00, wb}, 8'h00);
   endtask : wt
   task automatic results();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 6000) begin
         err_total++;
         results();
      end
   end
   initial begin
      seed = 49;
      {rst_n, abort_req, u_wr, u_rd, u_addr, u_wdata} = '0;
      for (i = 0; i < 4096; i++) fl_m[i] = 14'($random(seed));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 8; i++) rdc(3'(i), 8'h00, "reset");
      ew(8'h10, 8'h3C);
      rdc(EAC_CTRL, 8'h04, "pwrt");
      repeat (PWRT) idle();
      // broken sequences: no write allow, keys swapped, access between
      for (i = 0; i < 4; i++) begin
         wr_t(EAC_CTRL, i == 0 ? 8'h00 : 8'h04);
         wr_t(EAC_UNLK, i == 1 ? EAC_KEY2 : EAC_KEY1);
         if (i == 2) rdc(EAC_DATL, 8'h3C, "datl");
         wr_t(EAC_UNLK, i == 1 ? EAC_KEY1 : EAC_KEY2);
         if (i == 3) wr_t(EAC_ADRL, 8'h10);
         wr_t(EAC_CTRL, i == 0 ? 8'h02 : 8'h06);
         rdc(EAC_CTRL, i == 0 ? 8'h00 : 8'h04, "refuse");
      end
      for (i = 0; i < 3; i++) begin
         a = (i < 2) ? 8'h5A : 8'($random(seed));
         d = 8'($random(seed));
         ee_m[a] = d;
         aq.push_back(a);
         ew(a, d);
         rdc(EAC_CTRL, 8'h06, "started");
         if (i == 1) begin
            wr_t(EAC_CTRL, 8'h00);
            rdc(EAC_CTRL, 8'h02, "kept");
         end
         wt();
         rdc(EAC_CTRL, i == 1 ? 8'h00 : 8'h04, "done");
         rdc(EAC_FLAG, 8'h01, "flag");
         chk("wc", {7'h00, wc}, 8'h01);
         wr_t(EAC_FLAG, 8'h00);
         rdc(EAC_FLAG, 8'h00, "flag clr");
         chk("wc clr", {7'h00, wc}, 8'h00);
      end
      foreach (aq[j]) begin
         wr_t(EAC_ADRL, 8'(aq[j]));
         wr_t(EAC_CTRL, 8'h01);
         rdc(EAC_CTRL, 8'h00, "rd clr");
         rdc(EAC_DATL, 8'(ee_m[aq[j]]), "ee");
         rdc(EAC_DATL, 8'(ee_m[aq[j]]), "hold");
      end
      for (i = 0; i < 3; i++) begin
         ah = 8'($random(seed));
         a  = 8'($random(seed));
         wr_t(EAC_ADRH, ah);
         wr_t(EAC_ADRL, a);
         wr_t(EAC_CTRL, 8'h81);
         idle();
         wr_t(EAC_DATL, 8'hFF);  // falls in the stolen cycle
         #1;
         chk("discard", {7'h00, u_discard}, 8'h01);
         rdc(EAC_DATL, fl_m[{ah[3:0], a}][7:0], "pm lo");
         chk("no discard", {7'h00, u_discard}, 8'h00);
         rdc(EAC_DATH, {2'b00, fl_m[{ah[3:0], a}][13:8]}, "pm hi");
         rdc(EAC_ADRH, {4'h0, ah[3:0]}, "adrh");
         rdc(EAC_CTRL, 8'h80, "pgd");
         unl(8'h86);
         rdc(EAC_CTRL, 8'h84, "pm write");
      end
      // reset request while a write runs
      wr_t(EAC_CTRL, 8'h00);
      ew(8'h21, 8'h77);
      abort_req <= 1'b1;
      idle();
      abort_req <= 1'b0;
      idle();
      rdc(EAC_CTRL, 8'h08, "abort");
      rdc(EAC_FLAG, 8'h00, "no flag");
      wr_t(EAC_CTRL, 8'h0C);
      unl(8'h0E);
      wt();
      rdc(EAC_CTRL, 8'h04, "abort clr");
      // ones into the unused top bits must still read back as zero
      wr_t(EAC_DATH, 8'hFF);
      rdc(EAC_DATH, 8'h3F, "dath wr");
      results();
   end
endmodule : testbench
`default_nettype wire
